// File: src/fault_pkg.sv
// constants, codes and timing shared by the fault readback block
// Function
// - fault sets flag and stores channel code
// - full latch ignores later faults until frame
// - select fall loads codes, releases fault flag
// - select rise re-arms latches only if valid
// - after re-arm, persisting fault flags again
// - primary enable high-low-high clears all latches
// - invalid frame writes no register
// - frame shifts sixteen bits, two per channel
// - running timers block latch updates
// - shorted load after blanking starts filter
// - filter end shorted: capture, gate low, retry
// - retry end: gate high, reblank, recheck
// - commanded off: gate low, check ground short
// - filter starts only entering abnormal state
// - status flag low while primary enable high and below open threshold
// - live code changes, latched code holds
// - re-arm takes live code, no fault no flag
// - two-bit code per fault type, unique
// - diagnostics off when either enable low
// - fault flag released if primary or select low
package fault_pkg;
    localparam int unsigned NUM_CH        = 6;
    localparam int unsigned FRAME_BITS    = 16;
    localparam int unsigned CNT_W         = 5;
    localparam int unsigned CODE_W        = 2;
    localparam int unsigned SYNC_W        = 3 + 4 * NUM_CH;
    localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
    localparam logic [CNT_W-1:0] CNT_MAX   = 5'h1F;
    localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;
    // fault codes, one per condition
    localparam logic [CODE_W-1:0] CODE_NONE  = 2'h0;
    localparam logic [CODE_W-1:0] CODE_OPEN  = 2'h1;
    localparam logic [CODE_W-1:0] CODE_GND   = 2'h2;
    localparam logic [CODE_W-1:0] CODE_SHORT = 2'h3;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BLANK_TIME_NS = 20000;
    localparam int unsigned FILT_TIME_NS  = 10000;
    localparam int unsigned RETRY_TIME_US = 10000;
    localparam int unsigned TMR_W         = 16;
    localparam int unsigned RETRY_W       = 24;
    localparam logic [TMR_W-1:0] BLANK_CYC =
        TMR_W'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] FILT_CYC =
        TMR_W'((FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned RETRY_CYC_DEF =
        (RETRY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // frame tracking states
    typedef enum logic {FRM_IDLE, FRM_ACTIVE} frame_state_t;
endpackage

// File: src/channel_diag.sv
// one channel's timers, gate drive and live fault code
`timescale 1ns/100ps
module channel_diag
    import fault_pkg::*;
#(
    parameter int unsigned RETRY_CYC = RETRY_CYC_DEF
) (
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              enable_in,      // both enables high
    input  wire logic              command_in,     // channel commanded on
    input  wire logic              above_ref_in,   // drain above shorted ref
    input  wire logic              below_ol_in,    // drain below open thresh
    input  wire logic              below_sg_in,    // drain below ground thresh
    output logic                   gate_out,
    output logic [CODE_W-1:0]      live_code_out,
    output logic                   detect_out      // one-cycle capture pulse
);
    logic               gate_reg, gate_next;
    logic [CODE_W-1:0]  live_reg, live_next;
    logic               det_reg, det_next;
    logic               cmd_q_reg, cmd_q_next;     // last command seen
    logic               en_q_reg, en_q_next;       // last enable seen
    logic [CODE_W-1:0]  zone_q_reg, zone_q_next;   // last comparator zone
    logic [TMR_W-1:0]   blank_reg, blank_next;
    logic [TMR_W-1:0]   filt_reg, filt_next;
    logic [RETRY_W-1:0] retry_reg, retry_next;
    logic [CODE_W-1:0]  zone;                      // current evaluated zone

    // zone from comparators, references depend on command state
    always_comb begin
        if (command_in) begin
            zone = above_ref_in ? CODE_SHORT : CODE_NONE;
        end else if (below_sg_in) begin
            zone = CODE_GND;
        end else begin
            zone = below_ol_in ? CODE_OPEN : CODE_NONE;
        end
    end

    // timers and gate sequencing
    always_comb begin
        gate_next   = gate_reg;
        live_next   = live_reg;
        det_next    = 1'b0;
        cmd_q_next  = command_in;
        en_q_next   = enable_in;
        zone_q_next = zone;
        blank_next  = blank_reg;
        filt_next   = filt_reg;
        retry_next  = retry_reg;
        if (!enable_in) begin
            // diagnostics off, everything idle
            gate_next  = 1'b0;
            live_next  = CODE_NONE;
            blank_next = '0;
            filt_next  = '0;
            retry_next = '0;
        end else if (!en_q_reg || command_in != cmd_q_reg) begin
            // enable rise or command change restarts blanking
            gate_next  = command_in;
            blank_next = BLANK_CYC;
            filt_next  = '0;
            retry_next = '0;
        end else begin
            if (blank_reg != '0) begin
                blank_next = blank_reg - 1'b1;
            end
            if (filt_reg != '0) begin
                filt_next = filt_reg - 1'b1;
            end
            if (retry_reg != '0) begin
                retry_next = retry_reg - 1'b1;
            end
            if (blank_reg == TMR_W'(1) || filt_reg == TMR_W'(1)) begin
                // evaluation only at timer end
                live_next = zone;
                if (zone != CODE_NONE) begin
                    det_next = 1'b1;
                    if (command_in) begin
                        gate_next  = 1'b0;
                        retry_next = RETRY_W'(RETRY_CYC);
                        filt_next  = '0;
                    end
                end
            end else if (blank_reg == '0 && zone != zone_q_reg) begin
                if (zone != CODE_NONE) begin
                    // only a move into an abnormal zone is filtered
                    filt_next = FILT_CYC;
                end else begin
                    live_next = CODE_NONE;
                    filt_next = '0;
                end
            end
            if (retry_reg == RETRY_W'(1) && command_in) begin
                // retry: turn back on and blank again
                gate_next  = 1'b1;
                blank_next = BLANK_CYC;
                filt_next  = '0;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gate_reg   <= 1'b0;
            live_reg   <= CODE_NONE;
            det_reg    <= 1'b0;
            cmd_q_reg  <= 1'b0;
            en_q_reg   <= 1'b0;
            zone_q_reg <= CODE_NONE;
            blank_reg  <= '0;
            filt_reg   <= '0;
            retry_reg  <= '0;
        end else begin
            gate_reg   <= gate_next;
            live_reg   <= live_next;
            det_reg    <= det_next;
            cmd_q_reg  <= cmd_q_next;
            en_q_reg   <= en_q_next;
            zone_q_reg <= zone_q_next;
            blank_reg  <= blank_next;
            filt_reg   <= filt_next;
            retry_reg  <= retry_next;
        end
    end

    assign gate_out      = gate_reg;
    assign live_code_out = live_reg;
    assign detect_out    = det_reg;
endmodule

// File: src/fault_latch_spi_readback.sv
// six-channel fault latches with serial readback and frame check
`timescale 1ns/100ps
module fault_latch_spi_readback
    import fault_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = RETRY_CYC_DEF
) (
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  sclk_in,             // serial link clock
    input  wire logic                  chip_select_n_in,
    input  wire logic                  mosi_in,
    input  wire logic                  primary_enable_in,
    input  wire logic                  secondary_enable_in,
    input  wire logic [NUM_CH-1:0]     command_in,
    input  wire logic [NUM_CH-1:0]     above_ref_in,        // drain > shorted ref
    input  wire logic [NUM_CH-1:0]     below_ol_in,         // drain < open thresh
    input  wire logic [NUM_CH-1:0]     below_sg_in,         // drain < ground thresh
    output logic                       miso_out,
    output logic [NUM_CH-1:0]          gate_drive_output_out,
    output logic                       fault_flag_n_out,
    output logic                       fault_flag_oe_out,
    output logic                       status_flag_n_out,
    output logic                       status_flag_oe_out,
    output logic [FRAME_BITS-1:0]      write_data_out,
    output logic                       write_strobe_out,
    output logic                       frame_error_out
);
    // synchronisers for every pin input except the serial clock and serial data
    logic [SYNC_W-1:0]        sync1_reg;                // first stage only
    logic [SYNC_W-1:0]        sync2_reg;                // safe to read
    logic                     primary_enable_s;
    logic                     secondary_enable_s;
    logic                     cs_s;
    logic [NUM_CH-1:0]        cmd_s;
    logic [NUM_CH-1:0]        above_s;
    logic [NUM_CH-1:0]        ol_s;
    logic [NUM_CH-1:0]        sg_s;
    logic                     enable_both;

    // per channel diagnostics results
    logic [NUM_CH-1:0]        gate_w;
    logic [NUM_CH-1:0]        det_w;
    logic [CODE_W*NUM_CH-1:0] live_w;

    // frame tracking and latches
    frame_state_t             frm_reg, frm_next;
    logic                     idle_reg, idle_next;    // holds link logic reset
    logic [FRAME_BITS-1:0]    snap_reg, snap_next;    // codes for the frame
    logic [CODE_W*NUM_CH-1:0] code_reg, code_next;    // latched fault codes
    logic [NUM_CH-1:0]        full_reg, full_next;    // latch holds data
    logic [FRAME_BITS-1:0]    wdata_reg, wdata_next;
    logic                     wstb_reg, wstb_next;
    logic                     err_reg, err_next;
    logic                     rearm;                  // valid frame end
    logic                     fault_oe_reg, fault_oe_next;
    logic                     stat_oe_reg, stat_oe_next;
    logic                     gate_reg;
    logic [NUM_CH-1:0]        gate_out_reg;

    // link clock domain
    logic [CNT_W-1:0]         lcnt_reg, lcnt_next;    // serial clocks seen
    logic [FRAME_BITS-1:0]    lsh_reg, lsh_next;      // outgoing shift
    logic [FRAME_BITS-1:0]    lrx_reg, lrx_next;      // incoming data
    logic                     lmiso_reg, lmiso_next;

    // two-flop synchroniser, the first stage feeds only the second
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            // select reads deselected and both enables off, so no frame starts at release
            sync1_reg <= {{(SYNC_W-3){1'b0}}, 3'h1};
            sync2_reg <= {{(SYNC_W-3){1'b0}}, 3'h1};
        end else begin
            sync1_reg <= {below_sg_in, below_ol_in, above_ref_in, command_in,
                          primary_enable_in, secondary_enable_in,
                          chip_select_n_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign cs_s        = sync2_reg[0];
    assign secondary_enable_s      = sync2_reg[1];
    assign primary_enable_s      = sync2_reg[2];
    assign cmd_s       = sync2_reg[3 +: NUM_CH];
    assign above_s     = sync2_reg[3 + NUM_CH +: NUM_CH];
    assign ol_s        = sync2_reg[3 + 2 * NUM_CH +: NUM_CH];
    assign sg_s        = sync2_reg[3 + 3 * NUM_CH +: NUM_CH];
    assign enable_both = primary_enable_s & secondary_enable_s;

    // one diagnostic engine per channel
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        channel_diag #(
            .RETRY_CYC     (RETRY_CYCLES)
        ) u_diag (
            .clk_in        (clk_in),
            .resetn_in     (resetn_in),
            .enable_in     (enable_both),
            .command_in    (cmd_s[c]),
            .above_ref_in  (above_s[c]),
            .below_ol_in   (ol_s[c]),
            .below_sg_in   (sg_s[c]),
            .gate_out      (gate_w[c]),
            .live_code_out (live_w[CODE_W*c +: CODE_W]),
            .detect_out    (det_w[c])
        );
    end

    // frame tracking, latches and flags
    always_comb begin
        frm_next      = frm_reg;
        idle_next     = idle_reg;
        snap_next     = snap_reg;
        wdata_next    = wdata_reg;
        wstb_next     = 1'b0;
        err_next      = err_reg;
        rearm         = 1'b0;
        case (frm_reg)
            FRM_IDLE: begin
                if (!cs_s) begin
                    // frame start: copy latches for readback
                    snap_next = FRAME_BITS'(code_reg);
                    idle_next = 1'b0;
                    frm_next  = FRM_ACTIVE;
                end
            end
            FRM_ACTIVE: begin
                if (cs_s) begin
                    // link clock is stopped here, its count is stable
                    idle_next = 1'b1;
                    frm_next  = FRM_IDLE;
                    if (lcnt_reg == CNT_FRAME) begin
                        rearm      = 1'b1;
                        wdata_next = lrx_reg;
                        wstb_next  = 1'b1;
                        err_next   = 1'b0;
                    end else begin
                        err_next   = 1'b1;
                    end
                end
            end
            default: begin
                frm_next  = FRM_IDLE;
                idle_next = 1'b1;
            end
        endcase
    end

    // latches per channel
    always_comb begin
        code_next = code_reg;
        full_next = full_reg;
        for (int c = 0; c < NUM_CH; c++) begin
            if (!primary_enable_s) begin
                // primary enable low clears, rising re-arms
                code_next[CODE_W*c +: CODE_W] = CODE_NONE;
                full_next[c] = 1'b0;
            end else if (rearm) begin
                // re-arm takes the present live code
                code_next[CODE_W*c +: CODE_W] = live_w[CODE_W*c +: CODE_W];
                full_next[c] = live_w[CODE_W*c +: CODE_W] != CODE_NONE;
            end else if (!full_reg[c] && det_w[c]) begin
                // an armed latch takes the first detection only
                code_next[CODE_W*c +: CODE_W] = live_w[CODE_W*c +: CODE_W];
                full_next[c] = 1'b1;
            end
        end
    end

    // open-drain flags, driven low only while primary enable is high
    always_comb begin
        fault_oe_next = primary_enable_s & secondary_enable_s & cs_s & (|full_reg);
        stat_oe_next  = primary_enable_s & (|ol_s);
    end

    // clock domain registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frm_reg      <= FRM_IDLE;
            idle_reg     <= 1'b1;
            snap_reg     <= FRAME_RESET;
            code_reg     <= '0;
            full_reg     <= '0;
            wdata_reg    <= FRAME_RESET;
            wstb_reg     <= 1'b0;
            err_reg      <= 1'b0;
            fault_oe_reg <= 1'b0;
            stat_oe_reg  <= 1'b0;
            gate_out_reg <= '0;
        end else begin
            frm_reg      <= frm_next;
            idle_reg     <= idle_next;
            snap_reg     <= snap_next;
            code_reg     <= code_next;
            full_reg     <= full_next;
            wdata_reg    <= wdata_next;
            wstb_reg     <= wstb_next;
            err_reg      <= err_next;
            fault_oe_reg <= fault_oe_next;
            stat_oe_reg  <= stat_oe_next;
            gate_out_reg <= gate_w;
        end
    end

    // link side: shift on each rising serial clock
    always_comb begin
        lcnt_next  = lcnt_reg;
        lsh_next   = {lsh_reg[FRAME_BITS-2:0], 1'b0};
        lrx_next   = {lrx_reg[FRAME_BITS-2:0], mosi_in};
        lmiso_next = lsh_reg[FRAME_BITS-1];
        if (lcnt_reg != CNT_MAX) begin
            // saturate so a long frame never wraps to sixteen
            lcnt_next = lcnt_reg + 1'b1;
        end
        if (lcnt_reg == '0) begin
            // snapshot is static for the whole frame
            lmiso_next = snap_reg[FRAME_BITS-1];
            lsh_next   = {snap_reg[FRAME_BITS-2:0], 1'b0};
        end
    end

    // link registers held in reset between frames by the clock domain
    always_ff @(posedge sclk_in or posedge idle_reg) begin
        if (idle_reg) begin
            lcnt_reg  <= '0;
            lsh_reg   <= FRAME_RESET;
            lrx_reg   <= FRAME_RESET;
            lmiso_reg <= 1'b0;
        end else begin
            lcnt_reg  <= lcnt_next;
            lsh_reg   <= lsh_next;
            lrx_reg   <= lrx_next;
            lmiso_reg <= lmiso_next;
        end
    end

    assign gate_reg              = 1'b0;
    assign miso_out              = lmiso_reg;
    assign gate_drive_output_out = gate_out_reg;
    assign fault_flag_oe_out     = fault_oe_reg;
    assign fault_flag_n_out      = gate_reg;
    assign status_flag_oe_out    = stat_oe_reg;
    assign status_flag_n_out     = gate_reg;
    assign write_data_out        = wdata_reg;
    assign write_strobe_out      = wstb_reg;
    assign frame_error_out       = err_reg;
endmodule

// File: testbench/fault_latch_spi_readback_asserts.sv
// port-level assertions for the fault readback block
`timescale 1ns/100ps
module fault_latch_spi_readback_checker
    import fault_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = RETRY_CYC_DEF
) (
    input wire logic                  clk_in,
    input wire logic                  resetn_in,
    input wire logic                  chip_select_n_in,
    input wire logic                  primary_enable_in,
    input wire logic                  secondary_enable_in,
    input wire logic [NUM_CH-1:0]     below_ol_in,
    input wire logic                  miso_out,
    input wire logic [NUM_CH-1:0]     gate_drive_output_out,
    input wire logic                  fault_flag_oe_out,
    input wire logic                  status_flag_oe_out,
    input wire logic [FRAME_BITS-1:0] write_data_out,
    input wire logic                  write_strobe_out,
    input wire logic                  frame_error_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    // five samples cover the two-stage synchroniser plus the output register
    sequence s_cs_low;
        !chip_select_n_in [*5];
    endsequence
    sequence s_pen_low;
        !primary_enable_in [*5];
    endsequence
    sequence s_any_en_low;
        (!primary_enable_in || !secondary_enable_in) [*5];
    endsequence
    property p_flag_cs_off;
        s_cs_low |-> !fault_flag_oe_out;
    endproperty
    property p_flag_en_off;
        s_pen_low |-> !fault_flag_oe_out;
    endproperty
    property p_gate_en_off;
        s_any_en_low |-> gate_drive_output_out == '0;
    endproperty
    property p_stat_set;
        (primary_enable_in && (|below_ol_in)) [*6] |-> status_flag_oe_out;
    endproperty
    property p_stat_clr;
        (!primary_enable_in || below_ol_in == '0) [*6] |-> !status_flag_oe_out;
    endproperty
    property p_strobe_pulse;
        write_strobe_out |=> !write_strobe_out;
    endproperty
    // a write only follows a frame that ended cleanly
    property p_strobe_ok;
        write_strobe_out |-> !frame_error_out && $past(chip_select_n_in, 2);
    endproperty
    property p_data_hold;
        $changed(write_data_out) |-> write_strobe_out;
    endproperty
    property p_miso_idle;
        chip_select_n_in [*4] |-> !miso_out;
    endproperty
    a_flag_cs_off: assert property (p_flag_cs_off)
        else $error("fault flag on while selected");
    a_flag_en_off: assert property (p_flag_en_off)
        else $error("fault flag on while disabled");
    a_gate_en_off: assert property (p_gate_en_off)
        else $error("gate driven while disabled");
    a_stat_set: assert property (p_stat_set)
        else $error("status flag missing");
    a_stat_clr: assert property (p_stat_clr)
        else $error("status flag stuck");
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("write strobe too long");
    a_strobe_ok: assert property (p_strobe_ok)
        else $error("write after bad frame");
    a_data_hold: assert property (p_data_hold)
        else $error("write data changed without strobe");
    a_miso_idle: assert property (p_miso_idle)
        else $error("serial out busy while idle");
endmodule
bind fault_latch_spi_readback fault_latch_spi_readback_checker #(
    .RETRY_CYCLES(RETRY_CYCLES)
) chk (.clk_in, .resetn_in, .chip_select_n_in, .primary_enable_in,
    .secondary_enable_in, .below_ol_in, .miso_out, .gate_drive_output_out,
    .fault_flag_oe_out, .status_flag_oe_out, .write_data_out, .write_strobe_out,
    .frame_error_out);

// File: testbench/spi_host_model.sv
// behavioural serial host that runs one frame per go request
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic        go_in,
    input  wire logic [4:0]  pulses_in,   // clock pulses, 16 for a valid frame
    input  wire logic [15:0] tx_in,
    input  wire logic        miso_in,
    output logic             sclk_out,
    output logic             cs_n_out,
    output logic             mosi_out,
    output logic [15:0]      rx_out,
    output logic             done_out
);
    // sclk stands still while deselected; 125 ns period inside frames
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        rx_out = 16'h0000;
        done_out = 1'b0;
        forever begin
            @(posedge go_in);
            done_out = 1'b0;
            cs_n_out = 1'b0;
            #150; // select lead time before the first edge
            for (int k = 0; k < 32'(pulses_in); k++) begin
                // msb first; extra pulses toggle, the first carrying the inverse of the last bit
                mosi_out = (k < 16) ? tx_in[15 - k] : ~mosi_out;
                #62.5 sclk_out = 1'b1;
                #62.5 sclk_out = 1'b0;
                rx_out = {rx_out[14:0], miso_in};
            end
            // off the system clock edge so the select synchroniser never races
            #102.5 cs_n_out = 1'b1;
            mosi_out = ~mosi_out; // released line must not look stable
            #150 done_out = 1'b1;
        end
    end
endmodule

// File: testbench/fault_latch_spi_readback_test.sv
// self-checking bench for the fault readback block
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fault_latch_spi_readback_test
    import fault_pkg::*;
();
    logic              clk = 1'b0;
    logic              resetn = 1'b0;   // active low reset
    logic              pri_en = 1'b0;
    logic              sec_en = 1'b0;
    logic [NUM_CH-1:0] cmd = '0;
    logic [NUM_CH-1:0] above = '0;      // drain above shorted ref
    logic [NUM_CH-1:0] blw_ol = '0;
    logic [NUM_CH-1:0] blw_sg = '0;
    logic              go = 1'b0;
    logic [4:0]        pulses = 5'h10;
    logic [15:0]       tx = 16'h0000;
    logic [15:0]       seed = 16'h003D; // fixed seed, repeatable run
    logic              sclk, cs_n, mosi, miso, flag_oe, stat_oe, wstrobe, ferr, done;
    logic [NUM_CH-1:0] gate;
    logic [15:0]       wdata, rx;
    int                n_fail = 0;
    int                n_checks = 0;
    int                n_strobe = 0;
    int                c;
    always #5 clk = ~clk;
    // count write pulses; they last only one cycle
    always @(posedge clk) if (wstrobe === 1'b1) n_strobe <= n_strobe + 1;
    fault_latch_spi_readback #(.RETRY_CYCLES(200)) dut (
        .clk_in(clk), .resetn_in(resetn), .sclk_in(sclk), .chip_select_n_in(cs_n),
        .mosi_in(mosi), .primary_enable_in(pri_en), .secondary_enable_in(sec_en),
        .command_in(cmd), .above_ref_in(above), .below_ol_in(blw_ol),
        .below_sg_in(blw_sg), .miso_out(miso), .gate_drive_output_out(gate),
        .fault_flag_n_out(), .fault_flag_oe_out(flag_oe), .status_flag_n_out(),
        .status_flag_oe_out(stat_oe), .write_data_out(wdata),
        .write_strobe_out(wstrobe), .frame_error_out(ferr));
    spi_host_model host (.go_in(go), .pulses_in(pulses), .tx_in(tx), .miso_in(miso),
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .rx_out(rx), .done_out(done));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected frame word with one channel's code in place
    function automatic logic [15:0] word(input int ch, input logic [1:0] code);
        return 16'(code) << (2 * ch);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one frame of n pulses carrying random write data
    task automatic frame(input logic [4:0] n);
        int i;
        int s0;
        logic [15:0] w0;
        s0 = n_strobe;
        w0 = wdata;
        seed = lfsr(seed);
        pulses <= n;
        tx <= seed;
        go <= 1'b1;
        tick(10);
        `CHK(flag_oe, 1'b0)
        i = 0;
        while (done !== 1'b1 && i < 400) begin
            @(posedge clk);
            i++;
        end
        go <= 1'b0;
        tick(10); // frame-end update lands within four cycles
        `CHK(ferr, n != 5'h10)
        `CHK(wdata, (n == 5'h10) ? seed : w0)
        `CHK(n_strobe - s0, (n == 5'h10) ? 1 : 0)
    endtask
    initial begin
        #500000;
        n_fail++;
        wrap_up;
    end
    initial begin
        tick(6);
        resetn <= 1'b1;
        tick(5);
        pri_en <= 1'b1;
        sec_en <= 1'b1;
        tick(2100);
        frame(5'h10);
        `CHK(rx, 16'h0000)
        c = int'(lfsr(seed) % 6);
        cmd[c] <= 1'b1;
        above[c] <= 1'b1;
        tick(2100);
        `CHK(gate[c], 1'b0)
        `CHK(flag_oe, 1'b1)
        frame(5'h10);
        `CHK(rx, word(c, CODE_SHORT))
        `CHK(flag_oe, 1'b1)
        tick(300);
        `CHK(gate[c], 1'b1)
        tick(1650); // inside the retry wait after the blanking end
        `CHK(gate[c], 1'b0)
        cmd[c] <= 1'b0;
        above[c] <= 1'b0;
        blw_sg[c] <= 1'b1;
        blw_ol[c] <= 1'b1;
        tick(2100);
        frame(5'h10);
        `CHK(rx, word(c, CODE_SHORT))
        `CHK(flag_oe, 1'b1)
        blw_sg[c] <= 1'b0;
        tick(1100);
        `CHK(stat_oe, 1'b1)
        frame(5'h0F);
        frame(5'h11);
        frame(5'h10);
        `CHK(rx, word(c, CODE_GND))
        frame(5'h10);
        `CHK(rx, word(c, CODE_OPEN))
        blw_ol[c] <= 1'b0;
        tick(20);
        `CHK(stat_oe, 1'b0)
        frame(5'h10);
        `CHK(rx, word(c, CODE_OPEN))
        frame(5'h10);
        `CHK(rx, 16'h0000)
        `CHK(flag_oe, 1'b0)
        blw_sg[c] <= 1'b1;
        blw_ol[c] <= 1'b1;
        tick(2100);
        `CHK(flag_oe, 1'b1)
        pri_en <= 1'b0;
        tick(10);
        `CHK(flag_oe, 1'b0)
        pri_en <= 1'b1;
        tick(20);
        frame(5'h10);
        `CHK(rx, 16'h0000)
        blw_sg[c] <= 1'b0;
        blw_ol[c] <= 1'b0;
        cmd[c] <= 1'b1;
        tick(2100);
        `CHK(gate[c], 1'b1)
        above[c] <= 1'b1;
        tick(1100); // filter end, before the retry ends
        `CHK(gate[c], 1'b0)
        `CHK(flag_oe, 1'b1)
        tick(150);
        `CHK(gate[c], 1'b1)
        sec_en <= 1'b0;
        tick(10);
        `CHK(gate[c], 1'b0)
        wrap_up;
    end
endmodule
